// ===== verilog/tdcd_cfg_bank.v
// configuration bank for the time-sync measurement channel: register
// storage, address decode and the two delay-trim selections
// assumes a single-cycle strobe master on CORE_CLK that never waits
`timescale 1ns/10ps
`default_nettype none
`include "tdcd_defs.vh"

module tdcd_cfg_bank #(
   parameter [11:0] SYNC_LOOP_PS = 12'h3E8,
   parameter [11:0] SYNC_INPUT_PS = 12'h1F4,
   parameter [11:0] CLK_LOOP_PS = 12'h3E8,
   parameter [11:0] CLK_INPUT_PS = 12'h1F4
) (
   input wire CORE_CLK,
   input wire RESETN,
   input wire CE,
   input wire [15:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   output wire [11:0] SYNC_DLY_PS,
   output wire [11:0] CLK_DLY_PS,
   output wire [1:0] SYNC_FINE_SEL,
   output wire [1:0] SYNC_COARSE_SEL,
   output wire SYNC_BYPASS,
   output wire [1:0] CLK_FINE_SEL,
   output wire [1:0] CLK_COARSE_SEL,
   output wire CLK_BYPASS,
   output wire [3:0] COARSE_CLK_SEL,
   output reg COARSE_SEL_BAD,
   output wire [3:0] SIG1_SEL,
   output wire [3:0] SIG2_SEL,
   output wire [2:0] FANOUT_EN,
   output wire MEAS_NEG_EN,
   output wire MEAS_ONESHOT,
   output wire [31:0] MEAS_DIV_CFG,
   output wire [31:0] FB_DIV_CFG,
   output wire [7:0] MEAS_CTRL,
   output wire [7:0] QCOUNT_CTRL,
   output wire [7:0] QUEUE_CTRL,
   output wire [7:0] QREAD_REQ
);

   // ========================================================================
   // address decode

   // a hit needs the full byte address, base plus offset, so an address
   // inside a wider register never aliases onto it
   function hit;
      input [15:0] addr;
      input [7:0] idx;
      begin
         hit = (addr == (`TDCD_BASE + {8'h00, idx}));
      end
   endfunction

   wire wr_en = WR & CE;
   wire rd_en = RD & CE;

   // ========================================================================
   // fanout / delay register fields
   reg [1:0] sync_fine_r;
   reg [1:0] sync_coarse_r;
   reg sync_byp_r;
   reg [1:0] clk_fine_r;
   reg [1:0] clk_coarse_r;
   reg clk_byp_r;
   reg [3:0] cmux_r;
   reg [3:0] sig2_r;
   reg [3:0] sig1_r;
   reg [2:0] fan_en_r;

   // reserved ranges have no storage, so writes to them go nowhere
   always @(posedge CORE_CLK) begin
      if (!RESETN) begin
         sync_fine_r <= `TDCD_RST_FINE;
         sync_coarse_r <= `TDCD_RST_COARSE;
         sync_byp_r <= `TDCD_RST_BYP;
         clk_fine_r <= `TDCD_RST_FINE;
         clk_coarse_r <= `TDCD_RST_COARSE;
         clk_byp_r <= `TDCD_RST_BYP;
         cmux_r <= `TDCD_RST_CMUX;
         sig2_r <= `TDCD_RST_SIG2;
         sig1_r <= `TDCD_RST_SIG1;
         fan_en_r <= `TDCD_RST_FAN;
      end else if (wr_en && hit(ADDR, `TDCD_IDX_FANOUT)) begin
         sync_fine_r <= WDATA[`TDCD_SFINE_HI:`TDCD_SFINE_LO];
         sync_coarse_r <= WDATA[`TDCD_SCRS_HI:`TDCD_SCRS_LO];
         sync_byp_r <= WDATA[`TDCD_SBYP];
         clk_fine_r <= WDATA[`TDCD_CFINE_HI:`TDCD_CFINE_LO];
         clk_coarse_r <= WDATA[`TDCD_CCRS_HI:`TDCD_CCRS_LO];
         clk_byp_r <= WDATA[`TDCD_CBYP];
         cmux_r <= WDATA[`TDCD_CMUX_HI:`TDCD_CMUX_LO];
         sig2_r <= WDATA[`TDCD_SIG2_HI:`TDCD_SIG2_LO];
         sig1_r <= WDATA[`TDCD_SIG1_HI:`TDCD_SIG1_LO];
         fan_en_r <= WDATA[`TDCD_FAN_HI:`TDCD_FAN_LO];
      end
   end

   // ========================================================================
   // coarse clock source check

   // the mux is stored as written; only the flag tells of a reserved code,
   // because software owns this choice and the bank must not overrule it
   always @(posedge CORE_CLK) begin
      if (!RESETN) begin
         COARSE_SEL_BAD <= 1'b0;
      end else if (CE) begin
         COARSE_SEL_BAD <= (cmux_r != `TDCD_CMUX_TIMEREF);
      end
   end

   // ========================================================================
   // measurement configuration
   reg meas_neg_r;
   reg meas_mode_r;

   // negative results allowed, and one-shot versus continuous
   always @(posedge CORE_CLK) begin
      if (!RESETN) begin
         meas_neg_r <= 1'b0;
         meas_mode_r <= 1'b0;
      end else if (wr_en && hit(ADDR, `TDCD_IDX_MEAS)) begin
         meas_neg_r <= WDATA[`TDCD_NEG_BIT];
         meas_mode_r <= WDATA[`TDCD_MODE_BIT];
      end
   end

   // ========================================================================
   // divider words
   reg [31:0] mdiv_r;
   reg [31:0] fbdiv_r;

   // layouts unknown here, so the full word is held and passed on
   always @(posedge CORE_CLK) begin
      if (!RESETN) begin
         mdiv_r <= 32'h00000000;
         fbdiv_r <= 32'h00000000;
      end else if (wr_en) begin
         if (hit(ADDR, `TDCD_IDX_MDIV)) begin
            mdiv_r <= WDATA;
         end else if (hit(ADDR, `TDCD_IDX_FBDIV)) begin
            fbdiv_r <= WDATA;
         end
      end
   end

   // ========================================================================
   // byte-wide control registers
   localparam NBYTE = 4;

   // index of each byte register, in order of the output ports
   function [7:0] byte_idx;
      input integer i;
      begin
         case (i)
            0: byte_idx = `TDCD_IDX_MCTRL;
            1: byte_idx = `TDCD_IDX_QCNT;
            2: byte_idx = `TDCD_IDX_QCTRL;
            default: byte_idx = `TDCD_IDX_QREQ;
         endcase
      end
   endfunction

   reg [7:0] byte_r [0:NBYTE-1];
   wire [NBYTE-1:0] byte_hit;

   // one identical slice per byte register; bits above 7 are dropped
   genvar g;
   generate
      for (g = 0; g < NBYTE; g = g + 1) begin : g_byte
         assign byte_hit[g] = hit(ADDR, byte_idx(g));
         always @(posedge CORE_CLK) begin
            if (!RESETN) begin
               byte_r[g] <= 8'h00;
            end else if (wr_en && byte_hit[g]) begin
               byte_r[g] <= WDATA[7:0];
            end
         end
      end
   endgenerate

   // ========================================================================
   // read-back

   // whole fanout word with reserved ranges forced to zero
   wire [31:0] fanout_word = {
      3'h0,
      sync_fine_r, sync_coarse_r, sync_byp_r,
      3'h0,
      clk_fine_r, clk_coarse_r, clk_byp_r,
      cmux_r, sig2_r, sig1_r,
      1'b0, fan_en_r
   };

   reg [31:0] rd_nxt;

   // queue value, status and event words belong to the converter, which
   // is not in this bank, so they read zero like any unmapped address
   always @* begin
      rd_nxt = 32'h00000000;
      if (!rd_en) begin
         rd_nxt = 32'h00000000;
      end else if (hit(ADDR, `TDCD_IDX_FANOUT)) begin
         rd_nxt = fanout_word;
      end else if (hit(ADDR, `TDCD_IDX_MEAS)) begin
         rd_nxt = {30'h00000000, meas_neg_r, meas_mode_r};
      end else if (hit(ADDR, `TDCD_IDX_MDIV)) begin
         rd_nxt = mdiv_r;
      end else if (hit(ADDR, `TDCD_IDX_FBDIV)) begin
         rd_nxt = fbdiv_r;
      end else if (byte_hit[0]) begin
         rd_nxt = {24'h000000, byte_r[0]};
      end else if (byte_hit[1]) begin
         rd_nxt = {24'h000000, byte_r[1]};
      end else if (byte_hit[2]) begin
         rd_nxt = {24'h000000, byte_r[2]};
      end else if (byte_hit[3]) begin
         rd_nxt = {24'h000000, byte_r[3]};
      end
   end

   // read data stand for one cycle only, zero otherwise; a frozen clock
   // enable holds the last value rather than clearing it
   always @(posedge CORE_CLK) begin
      if (!RESETN) begin
         RDATA <= 32'h00000000;
      end else if (CE) begin
         RDATA <= rd_nxt;
      end
   end

   // ========================================================================
   // delay-trim paths

   // sync path: code 2 adds on top of the input-path base
   tdcd_dly_sel #(
      .LOOP_PS(SYNC_LOOP_PS),
      .INPUT_PS(SYNC_INPUT_PS),
      .PLUS_FROM_LOOP(0)
   ) u_sync_dly (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .ce(CE),
      .fine(sync_fine_r),
      .coarse(sync_coarse_r),
      .byp(sync_byp_r),
      .dly_ps_r(SYNC_DLY_PS)
   );

   // clock path: code 2 adds on top of the loopback base
   tdcd_dly_sel #(
      .LOOP_PS(CLK_LOOP_PS),
      .INPUT_PS(CLK_INPUT_PS),
      .PLUS_FROM_LOOP(1)
   ) u_clk_dly (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .ce(CE),
      .fine(clk_fine_r),
      .coarse(clk_coarse_r),
      .byp(clk_byp_r),
      .dly_ps_r(CLK_DLY_PS)
   );

   // ========================================================================
   // field outputs, straight from the storage flops
   assign SYNC_FINE_SEL = sync_fine_r;
   assign SYNC_COARSE_SEL = sync_coarse_r;
   assign SYNC_BYPASS = sync_byp_r;
   assign CLK_FINE_SEL = clk_fine_r;
   assign CLK_COARSE_SEL = clk_coarse_r;
   assign CLK_BYPASS = clk_byp_r;
   assign COARSE_CLK_SEL = cmux_r;
   assign SIG1_SEL = sig1_r;
   assign SIG2_SEL = sig2_r;
   assign FANOUT_EN = fan_en_r;
   assign MEAS_NEG_EN = meas_neg_r;
   assign MEAS_ONESHOT = meas_mode_r;
   assign MEAS_DIV_CFG = mdiv_r;
   assign FB_DIV_CFG = fbdiv_r;
   assign MEAS_CTRL = byte_r[0];
   assign QCOUNT_CTRL = byte_r[1];
   assign QUEUE_CTRL = byte_r[2];
   assign QREAD_REQ = byte_r[3];

endmodule // tdcd_cfg_bank

`default_nettype wire

// ===== verilog/tdcd_defs.vh
// constants for the measurement-channel delay configuration bank
// assumes byte addressing, each register at the base plus its own offset
`ifndef TDCD_DEFS_VH
`define TDCD_DEFS_VH

// ==========================================================================
// address map
`define TDCD_AW 16
`define TDCD_BASE 16'h0B00
`define TDCD_IDX_FANOUT 8'h00
`define TDCD_IDX_MEAS 8'h04
`define TDCD_IDX_MDIV 8'h08
`define TDCD_IDX_FBDIV 8'h0C
`define TDCD_IDX_MCTRL 8'h10
`define TDCD_IDX_QCNT 8'h11
`define TDCD_IDX_QCTRL 8'h12
`define TDCD_IDX_QREQ 8'h2F
`define TDCD_IDX_QVAL_LO 8'h30
`define TDCD_IDX_QVAL_HI 8'h31
`define TDCD_IDX_QSTS 8'h38
`define TDCD_IDX_QEVT 8'h39

// ==========================================================================
// fanout / delay register fields
`define TDCD_SFINE_HI 28
`define TDCD_SFINE_LO 27
`define TDCD_SCRS_HI 26
`define TDCD_SCRS_LO 25
`define TDCD_SBYP 24
`define TDCD_CFINE_HI 20
`define TDCD_CFINE_LO 19
`define TDCD_CCRS_HI 18
`define TDCD_CCRS_LO 17
`define TDCD_CBYP 16
`define TDCD_CMUX_HI 15
`define TDCD_CMUX_LO 12
`define TDCD_SIG2_HI 11
`define TDCD_SIG2_LO 8
`define TDCD_SIG1_HI 7
`define TDCD_SIG1_LO 4
`define TDCD_FAN_HI 2
`define TDCD_FAN_LO 0
`define TDCD_NEG_BIT 1
`define TDCD_MODE_BIT 0

// ==========================================================================
// reset values
`define TDCD_RST_FINE 2'h0
`define TDCD_RST_COARSE 2'h1
`define TDCD_RST_BYP 1'h1
`define TDCD_RST_CMUX 4'h3
`define TDCD_CMUX_TIMEREF 4'h3
`define TDCD_RST_SIG2 4'h0
`define TDCD_RST_SIG1 4'h5
`define TDCD_RST_FAN 3'h0

// ==========================================================================
// delay figures in picoseconds
`define TDCD_DW 12
`define TDCD_FINE_STEP_PS 12'h019
`define TDCD_EXTRA_PS 12'h04B
`define TDCD_TRIM_PS 12'h078
`define TDCD_CODE_LOOP 2'h0
`define TDCD_CODE_INPUT 2'h1
`define TDCD_CODE_PLUS 2'h2
`define TDCD_CODE_MINUS 2'h3

`endif

// ===== verilog/tdcd_dly_sel.v
// one delay-trim path: turns fine, coarse and bypass settings into the
// total inserted delay in picoseconds, registered
// assumes the path base delays are given as parameters by the caller
`timescale 1ns/10ps
`default_nettype none
`include "tdcd_defs.vh"

module tdcd_dly_sel #(
   parameter [11:0] LOOP_PS = 12'h3E8,
   parameter [11:0] INPUT_PS = 12'h1F4,
   parameter PLUS_FROM_LOOP = 0
) (
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire [1:0] fine,
   input wire [1:0] coarse,
   input wire byp,
   output reg [11:0] dly_ps_r
);

   // ========================================================================
   // delay decode
   reg [11:0] base_ps;
   reg [11:0] fine_ps;
   reg [11:0] dly_ps_nxt;

   // coarse code picks a matched path, fine adds whole steps on top
   always @* begin
      case (coarse)
         `TDCD_CODE_LOOP: base_ps = LOOP_PS;
         `TDCD_CODE_INPUT: base_ps = INPUT_PS;
         `TDCD_CODE_PLUS: begin
            // the two paths differ in which base the extra rides on
            if (PLUS_FROM_LOOP != 0) begin
               base_ps = LOOP_PS + `TDCD_EXTRA_PS;
            end else begin
               base_ps = INPUT_PS + `TDCD_EXTRA_PS;
            end
         end
         default: base_ps = INPUT_PS - `TDCD_TRIM_PS;
      endcase
      fine_ps = `TDCD_FINE_STEP_PS * {10'h000, fine};
      if (byp) begin
         dly_ps_nxt = 12'h000;
      end else begin
         dly_ps_nxt = base_ps + fine_ps;
      end
   end

   // register the result so the trim sees a clean value
   always @(posedge clk) begin
      if (!rst_n) begin
         dly_ps_r <= 12'h000;
      end else if (ce) begin
         dly_ps_r <= dly_ps_nxt;
      end
   end

endmodule // tdcd_dly_sel

`default_nettype wire

// ===== verif/tdcd_cfg_bank_props.sv
// checker for the measurement delay bank: bus, field and delay relations
// assumes it is bound to tdcd_cfg_bank and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module tdcd_cfg_bank_props #(
   parameter [11:0] SYNC_LOOP_PS = 12'h3E8,
   parameter [11:0] SYNC_INPUT_PS = 12'h1F4,
   parameter [11:0] CLK_LOOP_PS = 12'h3E8,
   parameter [11:0] CLK_INPUT_PS = 12'h1F4
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic [15:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [11:0] SYNC_DLY_PS,
   input wire logic [11:0] CLK_DLY_PS,
   input wire logic [1:0] SYNC_FINE_SEL,
   input wire logic [1:0] SYNC_COARSE_SEL,
   input wire logic SYNC_BYPASS,
   input wire logic [1:0] CLK_FINE_SEL,
   input wire logic [1:0] CLK_COARSE_SEL,
   input wire logic CLK_BYPASS,
   input wire logic [3:0] COARSE_CLK_SEL,
   input wire logic COARSE_SEL_BAD,
   input wire logic [3:0] SIG1_SEL,
   input wire logic [3:0] SIG2_SEL,
   input wire logic [2:0] FANOUT_EN,
   input wire logic MEAS_NEG_EN,
   input wire logic MEAS_ONESHOT,
   input wire logic [31:0] MEAS_DIV_CFG,
   input wire logic [31:0] FB_DIV_CFG,
   input wire logic [7:0] MEAS_CTRL,
   input wire logic [7:0] QCOUNT_CTRL,
   input wire logic [7:0] QUEUE_CTRL,
   input wire logic [7:0] QREAD_REQ
);
   // =====
   // helpers
   // all delay-trim fields gathered so a stray write shows as one change
   wire [19:0] fan_f = {3'h0, SYNC_FINE_SEL, SYNC_COARSE_SEL, SYNC_BYPASS, 3'h0,
      CLK_FINE_SEL, CLK_COARSE_SEL, CLK_BYPASS, COARSE_CLK_SEL};

   // delay a path should carry for a given fine and coarse setting
   function automatic [11:0] dly(input [1:0] f, c, input [11:0] lp, ip, input pl);
      case (c)
         2'h0: dly = lp;
         2'h1: dly = ip;
         2'h2: dly = (pl ? lp : ip) + 12'h04B;
         default: dly = ip - 12'h078;
      endcase
      dly = dly + f * 12'h019;
   endfunction

   // =====
   // properties
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   sequence fan_wr;
      CE && WR && ADDR == 16'h0B00;
   endsequence
   sequence fan_rd;
      CE && RD && ADDR == 16'h0B00;
   endsequence

   fan_write_a: assert property (fan_wr |=>
      fan_f == {3'h0, $past(WDATA[28:24]), 3'h0, $past(WDATA[20:12])})
      else $error("fanout fields differ from written word");
   fan_read_a: assert property (fan_rd |=> RDATA[31:12] == fan_f &&
      RDATA[11:0] == {SIG2_SEL, SIG1_SEL, 1'b0, FANOUT_EN})
      else $error("fanout read word differs from fields");
   meas_write_a: assert property (CE && WR && ADDR == 16'h0B04 |=>
      {MEAS_NEG_EN, MEAS_ONESHOT} == $past(WDATA[1:0]))
      else $error("measurement fields differ from written word");
   div_write_a: assert property (CE && WR && ADDR == 16'h0B08 |=>
      MEAS_DIV_CFG == $past(WDATA))
      else $error("measurement divider differs from written word");
   fbdiv_write_a: assert property (CE && WR && ADDR == 16'h0B0C |=>
      FB_DIV_CFG == $past(WDATA))
      else $error("feedback divider differs from written word");
   mctrl_write_a: assert property (CE && WR && ADDR == 16'h0B10 |=>
      MEAS_CTRL == $past(WDATA[7:0]))
      else $error("measurement control differs from written byte");
   qcount_write_a: assert property (CE && WR && ADDR == 16'h0B11 |=>
      QCOUNT_CTRL == $past(WDATA[7:0]))
      else $error("queue count control differs from written byte");
   qctrl_write_a: assert property (CE && WR && ADDR == 16'h0B12 |=>
      QUEUE_CTRL == $past(WDATA[7:0]))
      else $error("queue control differs from written byte");
   qreq_write_a: assert property (CE && WR && ADDR == 16'h0B2F |=>
      QREAD_REQ == $past(WDATA[7:0]))
      else $error("queue read request differs from written byte");
   rdata_idle_a: assert property ($past(CE) && !$past(RD) |-> RDATA == 32'h0)
      else $error("read data not zero outside a read");
   stray_write_a: assert property (CE && WR && ADDR[15:8] != 8'h0B |=> $stable(fan_f))
      else $error("write outside the bank changed fields");
   sync_bypass_a: assert property ($past(CE) && $past(SYNC_BYPASS) |->
      SYNC_DLY_PS == 12'h000)
      else $error("sync delay nonzero while bypassed");
   clk_bypass_a: assert property ($past(CE) && $past(CLK_BYPASS) |->
      CLK_DLY_PS == 12'h000)
      else $error("clock delay nonzero while bypassed");
   sync_delay_a: assert property ($past(CE) && !$past(SYNC_BYPASS) |->
      SYNC_DLY_PS == dly($past(SYNC_FINE_SEL), $past(SYNC_COARSE_SEL), SYNC_LOOP_PS,
      SYNC_INPUT_PS, 1'b0))
      else $error("sync delay value wrong");
   clk_delay_a: assert property ($past(CE) && !$past(CLK_BYPASS) |->
      CLK_DLY_PS == dly($past(CLK_FINE_SEL), $past(CLK_COARSE_SEL), CLK_LOOP_PS,
      CLK_INPUT_PS, 1'b1))
      else $error("clock delay value wrong");
   coarse_flag_a: assert property ($past(CE) |->
      COARSE_SEL_BAD == ($past(COARSE_CLK_SEL) != 4'h3))
      else $error("coarse select flag wrong");
endmodule // tdcd_cfg_bank_props
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the measurement delay bank
// assumes the strobe bus of the bank and its default delay parameters
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // =====
   // signals
   localparam [11:0] LOOP_PS = 12'h3E8;
   localparam [11:0] INPUT_PS = 12'h1F4;
   // register offsets, then an unused index and an unaligned slot
   localparam [111:0] OFFS = {8'h00, 8'h3E, 8'h39, 8'h38, 8'h31, 8'h30, 8'h2F, 8'h12,
      8'h11, 8'h10, 8'h0C, 8'h08, 8'h04, 8'h00};
   reg CORE_CLK = 1'b0, RESETN = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0;
   reg [15:0] ADDR = 16'h0B00;
   reg [31:0] WDATA = 32'h0;
   wire [31:0] RDATA;
   wire [11:0] SYNC_DLY_PS, CLK_DLY_PS;
   reg [31:0] shadow [0:255];
   reg [31:0] rd_q [$];
   reg [23:0] dly_q [$];
   reg rd_p = 1'b0, fw1 = 1'b0, fw2 = 1'b0;
   reg [15:0] a;
   reg [31:0] d;
   integer miscompares = 0, checks_done = 0, seed = 85997, i, k;

   tdcd_cfg_bank #(.SYNC_LOOP_PS(LOOP_PS), .SYNC_INPUT_PS(INPUT_PS), .CLK_LOOP_PS(LOOP_PS),
      .CLK_INPUT_PS(INPUT_PS)) i_tdcd_cfg_bank (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
      .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SYNC_DLY_PS(SYNC_DLY_PS), .CLK_DLY_PS(CLK_DLY_PS), .SYNC_FINE_SEL(),
      .SYNC_COARSE_SEL(), .SYNC_BYPASS(), .CLK_FINE_SEL(), .CLK_COARSE_SEL(), .CLK_BYPASS(),
      .COARSE_CLK_SEL(), .COARSE_SEL_BAD(), .SIG1_SEL(), .SIG2_SEL(), .FANOUT_EN(),
      .MEAS_NEG_EN(), .MEAS_ONESHOT(), .MEAS_DIV_CFG(), .FB_DIV_CFG(), .MEAS_CTRL(),
      .QCOUNT_CTRL(), .QUEUE_CTRL(), .QREAD_REQ());

   initial begin
      forever #10 CORE_CLK = ~CORE_CLK;
   end

   // =====
   // reference model
   // writable bits per index; converter-side and unused slots read zero
   function [31:0] mask_of(input [7:0] x);
      case (x)
         8'h00: mask_of = 32'h1F1FFFF7;
         8'h04: mask_of = 32'h00000003;
         8'h08, 8'h0C: mask_of = 32'hFFFFFFFF;
         8'h10, 8'h11, 8'h12, 8'h2F: mask_of = 32'h000000FF;
         default: mask_of = 32'h0;
      endcase
   endfunction

   // f is {fine, coarse, bypass}; pl picks the loop base for coarse code 2
   function [11:0] exp_dly(input [4:0] f, input pl);
      begin
         case (f[2:1])
            2'h0: exp_dly = LOOP_PS;
            2'h1: exp_dly = INPUT_PS;
            2'h2: exp_dly = (pl ? LOOP_PS : INPUT_PS) + 12'h04B;
            default: exp_dly = INPUT_PS - 12'h078;
         endcase
         exp_dly = f[0] ? 12'h000 : exp_dly + f[4:3] * 12'h019;
      end
   endfunction

   function [15:0] addr_of(input integer n);
      addr_of = 16'h0B00 + {8'h00, OFFS[n*8 +: 8]} + (n == 13 ? 16'h0002 : 16'h0000);
   endfunction

   // =====
   // bus tasks
   task wr(input [15:0] wa, input [31:0] v);
      begin
         @(posedge CORE_CLK);
         WR <= 1'b1;
         RD <= 1'b0;
         ADDR <= wa;
         WDATA <= v;
         if (wa[15:8] == 8'h0B && CE)
            shadow[wa[7:0]] = v & mask_of(wa[7:0]);
         if (wa == 16'h0B00 && CE)
            dly_q.push_back({exp_dly(v[28:24], 1'b0), exp_dly(v[20:16], 1'b1)});
      end
   endtask

   task rd(input [15:0] ra);
      begin
         @(posedge CORE_CLK);
         WR <= 1'b0;
         RD <= 1'b1;
         ADDR <= ra;
         rd_q.push_back((ra[15:8] == 8'h0B) ?
            shadow[ra[7:0]] & mask_of(ra[7:0]) : 32'h0);
      end
   endtask

   task idle(input integer n);
      begin
         @(posedge CORE_CLK);
         WR <= 1'b0;
         RD <= 1'b0;
         repeat (n) @(posedge CORE_CLK);
      end
   endtask

   // synchronous reset held five edges; shadow back to reset values
   task do_reset;
      begin
         @(posedge CORE_CLK);
         RESETN <= 1'b0;
         repeat (5) @(posedge CORE_CLK);
         RESETN <= 1'b1;
         for (i = 0; i < 256; i = i + 1)
            shadow[i] = 32'h0;
         shadow[0] = 32'h03033050;
      end
   endtask

   // =====
   // comparison and verdict
   task chk_rd(input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (RDATA !== e) begin
            miscompares = miscompares + 1;
            $display("BAD RDATA expected %h seen %h", e, RDATA);
         end
      end
   endtask

   task chk_dly(input [23:0] e);
      begin
         checks_done = checks_done + 1;
         if ({SYNC_DLY_PS, CLK_DLY_PS} !== e) begin
            miscompares = miscompares + 1;
            $display("BAD DLY_PS expected %h seen %h", e, {SYNC_DLY_PS, CLK_DLY_PS});
         end
      end
   endtask

   task tally_and_finish;
      begin
         // an expectation left unanswered counts as a miss
         if (rd_q.size() != 0 || dly_q.size() != 0)
            miscompares = miscompares + 1;
         if (miscompares == 0 && checks_done > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   // monitor: read data one edge after the strobe, delays two after a write
   always @(posedge CORE_CLK) begin
      rd_p <= RD && CE && RESETN;
      fw1 <= WR && CE && RESETN && ADDR == 16'h0B00;
      fw2 <= fw1 && RESETN;
      if (rd_p)
         chk_rd(rd_q.pop_front());
      if (fw2)
         chk_dly(dly_q.pop_front());
   end

   // watchdog well beyond the few hundred cycles the run needs
   initial begin
      #(20 * 4000);
      miscompares = miscompares + 1;
      tally_and_finish;
   end

   // =====
   // main sequence
   initial begin
      do_reset;
      for (k = 0; k < 14; k = k + 1)
         rd(addr_of(k));
      // every fine/coarse/bypass combination on both paths, back to back
      for (k = 0; k < 32; k = k + 1) begin
         d = $random(seed);
         d[15:12] = 4'h3;
         d[28:24] = k[4:0];
         d[20:16] = ~k[4:0];
         wr(16'h0B00, d);
         rd(16'h0B00);
      end
      // random traffic over mapped, unused and unaligned slots
      for (k = 0; k < 200; k = k + 1) begin
         a = addr_of($unsigned($random(seed)) % 14);
         if ($random(seed) & 1)
            wr(a, $random(seed));
         else
            rd(a);
      end
      idle(2);
      // write frozen by the clock enable, then a write at a foreign base
      CE <= 1'b0;
      wr(16'h0B00, 32'h1F1FFFF7);
      idle(0);
      CE <= 1'b1;
      wr(16'h1B00, 32'h0);
      rd(16'h0B00);
      idle(3);
      // second reset in mid-run restores the defaults
      do_reset;
      rd(16'h0B00);
      rd(16'h0B20);
      idle(4);
      tally_and_finish;
   end
endmodule // testbench

bind tdcd_cfg_bank tdcd_cfg_bank_props #(.SYNC_LOOP_PS(SYNC_LOOP_PS),
   .SYNC_INPUT_PS(SYNC_INPUT_PS), .CLK_LOOP_PS(CLK_LOOP_PS),
   .CLK_INPUT_PS(CLK_INPUT_PS)) i_tdcd_cfg_bank_props (.CORE_CLK(CORE_CLK),
   .RESETN(RESETN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SYNC_DLY_PS(SYNC_DLY_PS), .CLK_DLY_PS(CLK_DLY_PS),
   .SYNC_FINE_SEL(SYNC_FINE_SEL), .SYNC_COARSE_SEL(SYNC_COARSE_SEL),
   .SYNC_BYPASS(SYNC_BYPASS), .CLK_FINE_SEL(CLK_FINE_SEL), .CLK_COARSE_SEL(CLK_COARSE_SEL),
   .CLK_BYPASS(CLK_BYPASS), .COARSE_CLK_SEL(COARSE_CLK_SEL), .COARSE_SEL_BAD(COARSE_SEL_BAD),
   .SIG1_SEL(SIG1_SEL), .SIG2_SEL(SIG2_SEL), .FANOUT_EN(FANOUT_EN),
   .MEAS_NEG_EN(MEAS_NEG_EN), .MEAS_ONESHOT(MEAS_ONESHOT), .MEAS_DIV_CFG(MEAS_DIV_CFG),
   .FB_DIV_CFG(FB_DIV_CFG), .MEAS_CTRL(MEAS_CTRL), .QCOUNT_CTRL(QCOUNT_CTRL),
   .QUEUE_CTRL(QUEUE_CTRL), .QREAD_REQ(QREAD_REQ));
`default_nettype wire
